// >>> common/cvs_pkg.sv
// constants of the core voltage scaling register bank
//
// Function
// - go bit ramps core to programmed code
// - go bit self-clears when transition ends
// - completion when internal code reaches target
// - source select: register or default pin
// - pin ground/supply starts at 1.3/1.55 V
// - three discharge enables, one per converter
// - control register 05h, resets to 40h
// - five-bit core code, 25 mV steps
// - core register resets 14h or 1Eh
// - core register reloads on five events
// - slew code doubles rate, 111 immediate
// - slew register 07h, resets 06h
// - two three-bit linear regulator codes
// - regulator codes reset to 011 (first), 010 (second)
// - written core code overrides default pin
// - power good reads zero during ramp/disabled
package cvs_pkg;

    // *********************************************
    // register map
    // *********************************************
    localparam logic [7:0] OFS_CONV_CTRL   = 8'h05;
    localparam logic [7:0] OFS_CORE_CODE   = 8'h06;
    localparam logic [7:0] OFS_SLEW        = 8'h07;
    localparam logic [7:0] OFS_LDO_VOLT    = 8'h08;

    localparam logic [7:0] CONV_CTRL_MASK  = 8'hc7;
    localparam logic [7:0] CORE_CODE_MASK  = 8'h1f;
    localparam logic [7:0] SLEW_MASK       = 8'h07;
    localparam logic [7:0] LDO_VOLT_MASK   = 8'h77;

    localparam logic [7:0] CONV_CTRL_RST   = 8'h40;
    localparam logic [7:0] CORE_CODE_RST   = 8'h14;
    localparam logic [7:0] CORE_CODE_BASE  = 8'h14;
    localparam logic [7:0] SLEW_RST        = 8'h06;
    localparam logic [7:0] LDO_VOLT_RST    = 8'h23;

    // field positions
    localparam int GO_BIT        = 7;
    localparam int SRC_SEL_BIT   = 6;
    localparam int DIS_HI        = 2;
    localparam int PIN_BIT_A     = 3;
    localparam int PIN_BIT_B     = 1;
    localparam int SECOND_LIN_LSB = 4;
    localparam int FIRST_LIN_LSB  = 0;

    localparam logic [2:0] SLEW_IMMEDIATE = 3'h7;

    // *********************************************
    // timing
    // *********************************************
    localparam int CLK_PERIOD_NS    = 25;
    localparam int STEP_UV          = 25000;
    localparam int SLOW_RATE_UV_US  = 150;
    // slowest step interval in ns, rounded down (longest time)
    localparam int STEP_SLOW_NS     = (STEP_UV * 1000) / SLOW_RATE_UV_US;
    localparam int STEP_SLOW_CYCLES = STEP_SLOW_NS / CLK_PERIOD_NS;

endpackage

// >>> design/cvs_ramp_timer.sv
// step interval timer for the core voltage ramp
`timescale 1ns/100ps
`default_nettype none
module cvs_ramp_timer #(
    parameter int BASE_CYCLES = cvs_pkg::STEP_SLOW_CYCLES
) (
    input  wire logic       mclk_i,
    input  wire logic       reset_n_i,
    input  wire logic       run_i,
    input  wire logic [2:0] slew_i,
    output logic            tick_o
);

    logic [15:0] cnt_q;
    logic [15:0] reload;

    // each slew code doubles the rate, so halve the interval
    always_comb begin
        reload = 16'((BASE_CYCLES >> slew_i) - 1);
    end

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cnt_q  <= 16'h0000;
            tick_o <= 1'b0;
        end else if (!run_i) begin
            cnt_q  <= reload;
            tick_o <= 1'b0;
        end else if (slew_i == cvs_pkg::SLEW_IMMEDIATE || cnt_q == 16'h0000) begin
            cnt_q  <= reload;
            tick_o <= 1'b1;
        end else begin
            cnt_q  <= cnt_q - 16'h0001;
            tick_o <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// >>> design/cvs_regs.sv
// core voltage scaling registers and dynamic transition engine
`timescale 1ns/100ps
`default_nettype none
module cvs_regs #(
    parameter int STEP_BASE_CYCLES = cvs_pkg::STEP_SLOW_CYCLES
) (
    input  wire logic       mclk_i,
    input  wire logic       reset_n_i,
    // register port from the serial engine
    input  wire logic       wr_en_i,
    input  wire logic       rd_en_i,
    input  wire logic [7:0] addr_i,
    input  wire logic [7:0] wdata_i,
    output logic      [7:0] rdata_o,
    // reload events and pins
    input  wire logic       undervoltage_lockout_i,
    input  wire logic       warm_reset_input_n_i,
    input  wire logic       power_on_reset_output_i,
    input  wire logic       clock_backup_low_i,
    input  wire logic       first_step_down_en_i,
    input  wire logic       core_step_down_en_i,
    input  wire logic       core_default_pin_i,
    input  wire logic       core_below_target_i,
    // to the regulators
    output logic      [4:0] core_rail_code_o,
    output logic            core_pin_ctrl_o,
    output logic      [2:0] discharge_en_o,
    output logic      [2:0] first_ldo_code_o,
    output logic      [2:0] second_ldo_code_o,
    output logic            transition_busy_o,
    output logic            power_good_low_o
);

    typedef enum logic [1:0] {
        CVS_IDLE = 2'b01,
        CVS_RAMP = 2'b10
    } cvs_state_t;

    // *********************************************
    // input synchronisers
    // *********************************************
    logic [4:0] sync1_q;
    logic [4:0] sync2_q;

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sync1_q <= 5'h03; // lockout reads asserted, warm reset inactive-high, pin reads ground
            sync2_q <= 5'h03;
        end else begin
            sync1_q <= {core_below_target_i, core_default_pin_i, clock_backup_low_i,
                        warm_reset_input_n_i, undervoltage_lockout_i};
            sync2_q <= sync1_q;
        end
    end

    logic undervoltage_lockout_s;
    logic warm_n_s;
    logic rtc_low_s;
    logic pin_s;
    logic below_s;
    assign undervoltage_lockout_s    = sync2_q[0];
    assign warm_n_s  = sync2_q[1];
    assign rtc_low_s = sync2_q[2];
    assign pin_s     = sync2_q[3];
    assign below_s   = sync2_q[4];

    // *********************************************
    // decode
    // *********************************************
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        return a == ofs;
    endfunction

    logic wr_ctrl;
    logic wr_core;
    logic wr_slew;
    logic wr_ldo;
    assign wr_ctrl = wr_en_i && hit(addr_i, cvs_pkg::OFS_CONV_CTRL);
    assign wr_core = wr_en_i && hit(addr_i, cvs_pkg::OFS_CORE_CODE);
    assign wr_slew = wr_en_i && hit(addr_i, cvs_pkg::OFS_SLEW);
    assign wr_ldo  = wr_en_i && hit(addr_i, cvs_pkg::OFS_LDO_VOLT);

    // core register reload: any of the five events
    logic core_reload;
    assign core_reload = undervoltage_lockout_s || !warm_n_s || power_on_reset_output_i || rtc_low_s
                         || (!first_step_down_en_i && !core_step_down_en_i);

    // default code carries the pin level in two bits
    logic [7:0] core_default;
    assign core_default = cvs_pkg::CORE_CODE_BASE
                          | (8'(pin_s) << cvs_pkg::PIN_BIT_A)
                          | (8'(pin_s) << cvs_pkg::PIN_BIT_B);

    // *********************************************
    // registers
    // *********************************************
    logic [7:0] ctrl_q;
    logic [7:0] core_q;
    logic [7:0] slew_q;
    logic [7:0] ldo_q;
    logic       core_written_q;
    logic       ramp_done;
    cvs_state_t state_q;

    // go: set by write wins over self-clear on completion
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ctrl_q <= cvs_pkg::CONV_CTRL_RST;
        end else if (undervoltage_lockout_s) begin
            ctrl_q <= cvs_pkg::CONV_CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl_q <= wdata_i & cvs_pkg::CONV_CTRL_MASK;
        end else if (ramp_done) begin
            ctrl_q[cvs_pkg::GO_BIT] <= 1'b0;
        end
    end

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            core_q         <= cvs_pkg::CORE_CODE_RST;
            core_written_q <= 1'b0;
        end else if (core_reload) begin
            core_q         <= core_default;
            core_written_q <= 1'b0;
        end else if (wr_core) begin
            core_q         <= wdata_i & cvs_pkg::CORE_CODE_MASK;
            core_written_q <= 1'b1;
        end
    end

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            slew_q <= cvs_pkg::SLEW_RST;
        end else if (undervoltage_lockout_s) begin
            slew_q <= cvs_pkg::SLEW_RST;
        end else if (wr_slew) begin
            slew_q <= wdata_i & cvs_pkg::SLEW_MASK;
        end
    end

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ldo_q <= cvs_pkg::LDO_VOLT_RST;
        end else if (undervoltage_lockout_s) begin
            ldo_q <= cvs_pkg::LDO_VOLT_RST;
        end else if (wr_ldo) begin
            ldo_q <= wdata_i & cvs_pkg::LDO_VOLT_MASK;
        end
    end

    // read data; unmapped offsets read zero
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rdata_o <= 8'h00;
        end else if (rd_en_i) begin
            unique case (addr_i)
                cvs_pkg::OFS_CONV_CTRL: rdata_o <= ctrl_q;
                cvs_pkg::OFS_CORE_CODE: rdata_o <= core_q;
                cvs_pkg::OFS_SLEW:      rdata_o <= slew_q;
                cvs_pkg::OFS_LDO_VOLT:  rdata_o <= ldo_q;
                default:                rdata_o <= 8'h00;
            endcase
        end
    end

    // *********************************************
    // transition engine
    // *********************************************
    logic [4:0] target;
    logic       step_tick;
    assign target = core_q[4:0];

    cvs_ramp_timer #(
        .BASE_CYCLES (STEP_BASE_CYCLES)
    ) u_timer (
        .mclk_i    (mclk_i),
        .reset_n_i (reset_n_i),
        .run_i     (state_q == CVS_RAMP),
        .slew_i    (slew_q[2:0]),
        .tick_o    (step_tick)
    );

    // done judged on the internal code only, not on the analog output
    assign ramp_done = (state_q == CVS_RAMP) && (core_rail_code_o == target);

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_q <= CVS_IDLE;
        end else if (undervoltage_lockout_s || core_reload) begin
            state_q <= CVS_IDLE;
        end else begin
            unique case (state_q)
                CVS_IDLE: begin
                    if (ctrl_q[cvs_pkg::GO_BIT]) begin
                        state_q <= CVS_RAMP;
                    end
                end
                CVS_RAMP: begin
                    if (ramp_done) begin
                        state_q <= CVS_IDLE;
                    end
                end
                default: state_q <= CVS_IDLE;
            endcase
        end
    end

    // internal code walks one step per tick, or jumps when immediate
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            core_rail_code_o <= cvs_pkg::CORE_CODE_RST[4:0];
        end else if (core_reload) begin
            core_rail_code_o <= core_default[4:0];
        end else if (state_q == CVS_RAMP && step_tick && core_rail_code_o != target) begin
            if (slew_q[2:0] == cvs_pkg::SLEW_IMMEDIATE) begin
                core_rail_code_o <= target;
            end else if (core_rail_code_o < target) begin
                core_rail_code_o <= core_rail_code_o + 5'h01;
            end else begin
                core_rail_code_o <= core_rail_code_o - 5'h01;
            end
        end
    end

    // *********************************************
    // outputs
    // *********************************************
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            core_pin_ctrl_o   <= 1'b1;
            discharge_en_o    <= 3'h0;
            first_ldo_code_o  <= cvs_pkg::LDO_VOLT_RST[2:0];
            second_ldo_code_o <= cvs_pkg::LDO_VOLT_RST[6:4];
            transition_busy_o <= 1'b0;
            power_good_low_o  <= 1'b0;
        end else begin
            // a divider on the pin only matters until software writes a code
            core_pin_ctrl_o   <= ctrl_q[cvs_pkg::SRC_SEL_BIT] && !core_written_q;
            discharge_en_o    <= ctrl_q[cvs_pkg::DIS_HI:0];
            first_ldo_code_o  <= ldo_q[cvs_pkg::FIRST_LIN_LSB +: 3];
            second_ldo_code_o <= ldo_q[cvs_pkg::SECOND_LIN_LSB +: 3];
            transition_busy_o <= (state_q == CVS_RAMP) && !ramp_done;
            power_good_low_o  <= below_s && core_step_down_en_i
                                 && !(state_q == CVS_RAMP);
        end
    end

    // *********************************************
    // checks
    // *********************************************
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!reset_n_i);

    chk_go_starts_ramp: assert property (
        state_q == CVS_IDLE && ctrl_q[7] && !undervoltage_lockout_s && !core_reload |=> state_q == CVS_RAMP)
        else $error("go bit did not start a transition");

    chk_go_self_clear: assert property (
        ramp_done && !wr_ctrl && !undervoltage_lockout_s |=> !ctrl_q[7] && state_q == CVS_IDLE)
        else $error("go bit not cleared on completion");

    chk_done_on_code: assert property (
        state_q == CVS_RAMP && core_rail_code_o == target && !core_reload
        |=> state_q == CVS_IDLE && !transition_busy_o)
        else $error("completion not flagged on code match");

    chk_pin_ctrl_out: assert property (
        ##1 core_pin_ctrl_o == $past(ctrl_q[6] && !core_written_q))
        else $error("pin control output wrong");

    chk_written_overrides: assert property (
        wr_core && !core_reload ##1 !core_reload [*2] |-> !core_pin_ctrl_o)
        else $error("pin still in control after code write");

    chk_core_reload_val: assert property (
        core_reload |=> core_q == {3'h0, 1'b1, $past(pin_s), 1'b1, $past(pin_s), 1'b0})
        else $error("core default value wrong");

    chk_undervoltage_lockout_defaults: assert property (
        undervoltage_lockout_s |=> ldo_q == 8'h23 && slew_q == 8'h06 && ctrl_q == 8'h40)
        else $error("lockout defaults wrong");

    chk_reserved_zero: assert property (
        (ctrl_q & 8'h38) == 8'h00 && core_q[7:5] == 3'h0 && slew_q[7:3] == 5'h00
        && ldo_q[7] == 1'b0 && ldo_q[3] == 1'b0)
        else $error("reserved bit set");

    chk_single_step: assert property (
        state_q == CVS_RAMP && slew_q[2:0] != 3'h7 && !core_reload
        |=> (core_rail_code_o == $past(core_rail_code_o))
            || (core_rail_code_o == $past(core_rail_code_o) + 5'h01)
            || (core_rail_code_o == $past(core_rail_code_o) - 5'h01))
        else $error("ramp moved more than one step");

    chk_immediate_jump: assert property (
        state_q == CVS_RAMP && slew_q[2:0] == 3'h7 && !core_reload && !wr_core && !wr_slew
        |-> ##[1:3] core_rail_code_o == target)
        else $error("immediate slew did not jump");

    chk_pgood_ramp: assert property (
        state_q == CVS_RAMP |=> !power_good_low_o)
        else $error("power good low during transition");

    cov_ramp_done: cover property (ramp_done);
    cov_ramp_down: cover property (state_q == CVS_RAMP && core_rail_code_o > target);
    cov_go_vs_done: cover property (ramp_done && wr_ctrl && wdata_i[7]);
    cov_reload_ramp: cover property (state_q == CVS_RAMP && core_reload);

endmodule
`default_nettype wire

// >>> test/cvs_host_model.sv
// host side model that issues register writes and reads
`timescale 1ns/100ps
`default_nettype none
module cvs_host_model (
    input  wire logic       mclk_i,
    output logic            wr_en_o,
    output logic            rd_en_o,
    output logic      [7:0] addr_o,
    output logic      [7:0] wdata_o
);
    initial begin
        wr_en_o = 1'b0;
        rd_en_o = 1'b0;
        addr_o = 8'h00;
        wdata_o = 8'h00;
    end

    // released bus lines show the inverse so stale values never pass
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk_i);
        addr_o = a;
        wdata_o = d;
        wr_en_o = 1'b1;
        @(negedge mclk_i);
        wr_en_o = 1'b0;
        addr_o = ~a;
        wdata_o = ~d;
    endtask

    task automatic read_reg(input logic [7:0] a);
        @(negedge mclk_i);
        addr_o = a;
        rd_en_o = 1'b1;
        @(negedge mclk_i);
        rd_en_o = 1'b0;
        addr_o = ~a;
    endtask
endmodule
`default_nettype wire

// >>> test/tb_cvs_regs.sv
// self-checking bench for the core voltage scaling registers
`timescale 1ns/100ps
`default_nettype none
module tb_cvs_regs;
    // short step interval keeps ramps brief, slew codes 0 to 6 stay >= 2
    localparam int BASE = 128;
    logic       mclk_i    = 1'b0;
    logic       reset_n_i = 1'b0;
    logic       wr_en, rd_en, pinctl, busy, pgl;
    logic [7:0] addr, wdata, rdata;
    logic [4:0] code;
    logic [2:0] dis, lin1, lin2;
    logic       undervoltage_lockout = 1'b0, warm_n = 1'b1, por = 1'b0, cbl = 1'b0;
    logic       en1 = 1'b1, en3 = 1'b1, pin = 1'b0, below = 1'b0;
    logic       rd_d = 1'b0;
    logic [7:0] exp_q[$];
    int         num_errors = 0;
    int         check_count = 0;
    int         seed = 32'h0073;

    always #12.5 mclk_i = ~mclk_i;

    cvs_host_model cvs_host_model_inst (.mclk_i(mclk_i), .wr_en_o(wr_en), .rd_en_o(rd_en),
        .addr_o(addr), .wdata_o(wdata));

    cvs_regs #(.STEP_BASE_CYCLES(BASE)) cvs_regs_inst (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
        .wr_en_i(wr_en), .rd_en_i(rd_en), .addr_i(addr), .wdata_i(wdata), .rdata_o(rdata),
        .undervoltage_lockout_i(undervoltage_lockout), .warm_reset_input_n_i(warm_n), .power_on_reset_output_i(por),
        .clock_backup_low_i(cbl), .first_step_down_en_i(en1), .core_step_down_en_i(en3),
        .core_default_pin_i(pin), .core_below_target_i(below), .core_rail_code_o(code),
        .core_pin_ctrl_o(pinctl), .discharge_en_o(dis), .first_ldo_code_o(lin1),
        .second_ldo_code_o(lin2), .transition_busy_o(busy), .power_good_low_o(pgl));

    // ****************************************
    // checking and closing
    // ****************************************
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up();
        $display("checks=%0d mismatches=%0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        cvs_host_model_inst.write_reg(a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        cvs_host_model_inst.read_reg(a);
    endtask

    task automatic idle(input int n);
        repeat (n) @(negedge mclk_i);
    endtask

    task automatic set_ev(input int k, input logic on);
        case (k)
            0: undervoltage_lockout = on;
            1: warm_n = ~on;
            2: por = on;
            3: cbl = on;
            default: begin
                en1 = ~on;
                en3 = ~on;
            end
        endcase
    endtask

    // read data lands one edge after the strobe
    always @(posedge mclk_i) rd_d <= rd_en;
    always @(negedge mclk_i) begin
        if (rd_d && exp_q.size() > 0) begin
            chk(rdata, exp_q.pop_front());
        end
    end

    initial begin
        #2500000;
        num_errors++;
        wrap_up();
    end

    // ****************************************
    // scenarios
    // ****************************************
    initial begin
        logic [7:0] r, cur, tgt;
        logic [4:0] prev;
        int         el, chg, lo;
        logic       seen;
        repeat (5) @(negedge mclk_i);
        reset_n_i = 1'b1;
        idle(5);
        rd(8'h05, 8'h40);
        rd(8'h06, 8'h14);
        rd(8'h07, 8'h06);
        rd(8'h08, 8'h23);
        rd(8'h09, 8'h00);
        chk({3'h0, code}, 8'h14);
        chk({1'b0, lin2, 1'b0, lin1}, 8'h23);
        chk({7'h0, pinctl}, 8'h01);
        $display("test reset values done");
        wr(8'h05, 8'h7f);
        rd(8'h05, 8'h47);
        for (int i = 0; i < 3; i++) begin
            wr(8'h05, 8'h40 | 8'(1 << i));
            idle(2);
            chk({5'h0, dis}, 8'(1 << i));
        end
        wr(8'h09, 8'hff);
        rd(8'h09, 8'h00);
        wr(8'h07, 8'hff);
        rd(8'h07, 8'h07);
        repeat (4) begin
            r = 8'($random(seed));
            wr(8'h08, r);
            rd(8'h08, r & 8'h77);
            idle(2);
            chk({1'b0, lin2, 1'b0, lin1}, r & 8'h77);
        end
        wr(8'h06, 8'hff);
        rd(8'h06, 8'h1f);
        idle(2);
        chk({7'h0, pinctl}, 8'h00);
        chk({3'h0, code}, 8'h14);
        $display("test access and fields done");
        pin = 1'b1;
        for (int k = 0; k < 5; k++) begin
            wr(8'h06, 8'h05);
            set_ev(k, 1'b1);
            idle(6);
            set_ev(k, 1'b0);
            idle(6);
            rd(8'h06, 8'h1e);
            chk({3'h0, code}, 8'h1e);
            chk({7'h0, pinctl}, 8'h01);
        end
        rd(8'h07, 8'h06);
        rd(8'h08, 8'h23);
        $display("test reload events done");
        wr(8'h05, 8'h00);
        below = 1'b1;
        cur = 8'h1e;
        for (int s = 0; s < 8; s++) begin
            tgt = (s % 2 == 1) ? cur + 8'h02 : cur - 8'h02;
            wr(8'h07, 8'(s));
            wr(8'h06, tgt);
            wr(8'h05, 8'h80);
            el = 0;
            chg = 0;
            seen = 1'b0;
            prev = code;
            while (el < 3000 && !(seen && busy === 1'b0)) begin
                idle(1);
                el++;
                if (busy === 1'b1) seen = 1'b1;
                if (s < 6 && el == (BASE >> s)) chk({7'h0, pgl}, 8'h00);
                if (code !== prev) chg++;
                prev = code;
            end
            if (el >= 3000) begin
                num_errors++;
                wrap_up();
            end
            lo = (s == 7) ? 0 : 2 * (BASE >> s);
            chk({3'h0, code}, tgt);
            chk(8'(chg), (s == 7) ? 8'h01 : 8'h02);
            chk({7'h0, (el >= lo && el <= lo + 8)}, 8'h01);
            rd(8'h05, 8'h00);
            cur = tgt;
        end
        $display("test ramps done");
        en3 = 1'b0;
        idle(6);
        chk({7'h0, pgl}, 8'h00);
        en3 = 1'b1;
        idle(6);
        chk({7'h0, pgl}, 8'h01);
        wr(8'h07, 8'h00);
        wr(8'h06, 8'h10);
        wr(8'h05, 8'h80);
        idle(50);
        chk({7'h0, busy}, 8'h01);
        set_ev(0, 1'b1);
        idle(5);
        set_ev(0, 1'b0);
        idle(6);
        chk({7'h0, busy}, 8'h00);
        rd(8'h05, 8'h40);
        chk({3'h0, code}, 8'h1e);
        $display("test power good and abort done");
        idle(2);
        wrap_up();
    end
endmodule
`default_nettype wire
